// ### design/timer_ccc_defines.vh
// Purpose: register map, field positions and reset values of the timer
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets are byte addresses on paddr
`ifndef TIMER_CCC_DEFINES_VH
`define TIMER_CCC_DEFINES_VH
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_EVT 8'h08
`define OFS_IEN 8'h0C
`define OFS_CHMODE 8'h10
`define OFS_CHEN 8'h14
`define OFS_CNT 8'h18
`define OFS_PSC 8'h1C
`define OFS_ARR 8'h20
`define OFS_REP 8'h24
`define OFS_CCV0 8'h28
`define OFS_CCV1 8'h2C
`define OFS_CCV2 8'h30
`define OFS_CCV3 8'h34
`define CTRL_RUN 0
`define CTRL_UBLK 1
`define CTRL_RBUF 2
`define CTRL_RESTART 3
`define CTRL_XOR 4
`define CTRL_DIR 8
`define STAT_UPF 0
`define STAT_CAPF 1
`define STAT_OVCF 9
`define EVT_FUG 0
`define EVT_SWE 1
`define IEN_UIE 0
`define IEN_CIE 1
`define IEN_CDE 9
`define ARR_RESET 16'hFFFF
`define SRC_OWN 2'b01
`define SRC_PAIR 2'b10
`endif

// ### design/timer_center_count_capture.v
// Purpose: centre-aligned counter with four input-capture channels, apb
// Assumes: channel pins asynchronous; apb zero wait state
// Notes: compare output stage is not built; only capture mode is active
`include "timer_ccc_defines.vh"

module timer_center_count_capture #(
  parameter CNT_W = 16,
  parameter PSC_W = 16,
  parameter REP_W = 8,
  parameter NCH = 4
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [NCH-1:0] chan_pin_i,
  output reg irq_o,
  output reg [NCH-1:0] dma_req_o
);

  // control and buffered copies
  reg [4:0] ctrl_q;
  reg uie_q;
  reg [NCH-1:0] cie_q;
  reg [NCH-1:0] cde_q;
  reg [31:0] chmode_q;
  reg [15:0] chen_q;
  reg [PSC_W-1:0] psc_buf_q;
  reg [PSC_W-1:0] psc_act_q;
  reg [PSC_W-1:0] psc_cnt_q;
  reg [CNT_W-1:0] arr_buf_q;
  reg [CNT_W-1:0] arr_act_q;
  reg [REP_W-1:0] rep_buf_q;
  reg [REP_W-1:0] rep_cnt_q;
  reg [CNT_W-1:0] cnt_q;
  reg dir_q;
  reg upf_q;

  wire wr_en = psel_i & penable_i & pwrite_i & pready_o;
  wire setup = psel_i & ~penable_i;
  wire wr_ctrl = wr_en & (paddr_i == `OFS_CTRL);
  wire wr_stat = wr_en & (paddr_i == `OFS_STAT);
  wire wr_evt = wr_en & (paddr_i == `OFS_EVT);
  wire wr_ien = wr_en & (paddr_i == `OFS_IEN);
  wire wr_chmode = wr_en & (paddr_i == `OFS_CHMODE);
  wire wr_chen = wr_en & (paddr_i == `OFS_CHEN);
  wire wr_cnt = wr_en & (paddr_i == `OFS_CNT);
  wire wr_psc = wr_en & (paddr_i == `OFS_PSC);
  wire wr_arr = wr_en & (paddr_i == `OFS_ARR);
  wire wr_rep = wr_en & (paddr_i == `OFS_REP);
  wire [3:0] wr_ccv = {wr_en & (paddr_i == `OFS_CCV3),
    wr_en & (paddr_i == `OFS_CCV2), wr_en & (paddr_i == `OFS_CCV1),
    wr_en & (paddr_i == `OFS_CCV0)};

  wire run = ctrl_q[`CTRL_RUN];
  wire ublk = ctrl_q[`CTRL_UBLK];
  wire rbuf = ctrl_q[`CTRL_RBUF];
  wire force_upd = wr_evt & pwdata_i[`EVT_FUG];
  wire [NCH-1:0] swe = {NCH{wr_evt}} & pwdata_i[`EVT_SWE +: NCH];

  // per-channel results gathered from the generate loop
  wire [NCH-1:0] ti_w;
  wire [NCH-1:0] sync_w;
  wire [NCH-1:0] frise_w;
  wire [NCH-1:0] ffall_w;
  wire [NCH-1:0] capf_w;
  wire [NCH-1:0] ovcf_w;
  wire [NCH-1:0] dma_w;
  wire [CNT_W*NCH-1:0] ccv_w;

  // restart on filtered first-channel rising edge
  wire restart = ctrl_q[`CTRL_RESTART] & frise_w[0];
  wire reinit = force_upd | restart;

  // prescaler tick
  wire tick = run & (psc_cnt_q == psc_act_q);

  // next count, centre-aligned
  reg [CNT_W-1:0] cnt_nx;
  reg dir_nx;
  reg ovf;
  reg unf;
  always @* begin
    cnt_nx = cnt_q;
    dir_nx = dir_q;
    ovf = 1'b0;
    unf = 1'b0;
    if (!dir_q) begin
      if (cnt_q >= arr_act_q) begin
        dir_nx = 1'b1;
        cnt_nx = (cnt_q == {CNT_W{1'b0}}) ? cnt_q : cnt_q - 1'b1;
      end else begin
        cnt_nx = cnt_q + 1'b1;
        ovf = (cnt_nx == arr_act_q - 1'b1);
      end
    end else begin
      if (cnt_q == {CNT_W{1'b0}}) begin
        dir_nx = 1'b0;
        cnt_nx = (arr_act_q == {CNT_W{1'b0}}) ? cnt_q : cnt_q + 1'b1;
      end else begin
        cnt_nx = cnt_q - 1'b1;
        unf = (cnt_nx == {{(CNT_W-1){1'b0}}, 1'b1});
      end
    end
  end

  wire turn = tick & (ovf | unf);
  // repetition counter gates overflow/underflow updates
  wire uev = ((turn & (rep_cnt_q == {REP_W{1'b0}})) | reinit) & ~ublk;

  // counter, prescaler, buffered loads
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_q <= {CNT_W{1'b0}};
      dir_q <= 1'b0;
      psc_cnt_q <= {PSC_W{1'b0}};
      psc_act_q <= {PSC_W{1'b0}};
      arr_act_q <= `ARR_RESET;
      rep_cnt_q <= {REP_W{1'b0}};
    end else begin
      if (reinit) begin
        cnt_q <= {CNT_W{1'b0}};
        dir_q <= 1'b0;
        psc_cnt_q <= {PSC_W{1'b0}};
      end else begin
        if (wr_cnt) begin
          cnt_q <= pwdata_i[CNT_W-1:0];
        end else if (tick) begin
          cnt_q <= cnt_nx;
          dir_q <= dir_nx;
        end
        if (!run || tick) begin
          psc_cnt_q <= {PSC_W{1'b0}};
        end else begin
          psc_cnt_q <= psc_cnt_q + 1'b1;
        end
      end
      if (uev) begin
        psc_act_q <= psc_buf_q;
        arr_act_q <= arr_buf_q;
        rep_cnt_q <= rep_buf_q;
      end else begin
        // a blocked update leaves the count at zero instead of wrapping
        if (turn && rep_cnt_q != {REP_W{1'b0}}) begin
          rep_cnt_q <= rep_cnt_q - 1'b1;
        end
        // unbuffered reload acts at once, except in a cycle where an update event loads the buffered value
        if (wr_arr && !rbuf) begin
          arr_act_q <= pwdata_i[CNT_W-1:0];
        end
      end
    end
  end

  // software-visible registers
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_q <= 5'h00;
      uie_q <= 1'b0;
      cie_q <= {NCH{1'b0}};
      cde_q <= {NCH{1'b0}};
      chmode_q <= 32'h0000_0000;
      chen_q <= 16'h0000;
      psc_buf_q <= {PSC_W{1'b0}};
      arr_buf_q <= `ARR_RESET;
      rep_buf_q <= {REP_W{1'b0}};
      upf_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata_i[4:0];
      end
      if (wr_ien) begin
        uie_q <= pwdata_i[`IEN_UIE];
        cie_q <= pwdata_i[`IEN_CIE +: NCH];
        cde_q <= pwdata_i[`IEN_CDE +: NCH];
      end
      if (wr_chmode) begin
        chmode_q <= pwdata_i;
      end
      if (wr_chen) begin
        chen_q <= pwdata_i[15:0];
      end
      if (wr_psc) begin
        psc_buf_q <= pwdata_i[PSC_W-1:0];
      end
      if (wr_arr) begin
        arr_buf_q <= pwdata_i[CNT_W-1:0];
      end
      if (wr_rep) begin
        rep_buf_q <= pwdata_i[REP_W-1:0];
      end
      // write one to clear; a new update in the same cycle wins
      upf_q <= (upf_q & ~(wr_stat & pwdata_i[`STAT_UPF])) | uev;
    end
  end

  // capture channels
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : gen_ch
      reg sync1_q;
      reg sync2_q;
      reg flt_q;
      reg [3:0] fcnt_q;
      reg [2:0] pcnt_q;
      reg capf_q;
      reg ovcf_q;
      reg dma_q;
      reg [CNT_W-1:0] ccv_q;
      wire [1:0] src = chmode_q[8*c +: 2];
      wire [1:0] ediv = chmode_q[8*c+2 +: 2];
      wire [3:0] fset = chmode_q[8*c+4 +: 4];
      wire en = chen_q[4*c];
      wire pol = chen_q[4*c+1];
      wire npol = chen_q[4*c+2];
      wire in_mode = (src != 2'b00);
      wire settle = (ti_w[c] != flt_q) && (fcnt_q >= fset);
      wire rise_s;
      wire fall_s;
      wire edge_s;
      wire [2:0] plim;
      wire cap_evt;
      wire cap;

      // two flops; only the second is looked at
      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          sync1_q <= 1'b0;
          sync2_q <= 1'b0;
        end else begin
          sync1_q <= chan_pin_i[c];
          sync2_q <= sync1_q;
        end
      end

      assign sync_w[c] = sync2_q;
      if (c == 0) begin : gen_xor
        assign ti_w[c] = ctrl_q[`CTRL_XOR] ?
          (sync_w[0] ^ sync_w[1] ^ sync_w[2]) :
          sync2_q;
      end else begin : gen_own
        assign ti_w[c] = sync2_q;
      end

      // level must hold fset+1 samples before the filter follows it
      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          flt_q <= 1'b0;
          fcnt_q <= 4'h0;
        end else if (ti_w[c] == flt_q || settle) begin
          fcnt_q <= 4'h0;
          if (settle) begin
            flt_q <= ti_w[c];
          end
        end else begin
          fcnt_q <= fcnt_q + 1'b1;
        end
      end

      assign frise_w[c] = settle & ti_w[c];
      assign ffall_w[c] = settle & ~ti_w[c];

      // own input or the paired channel's input
      assign rise_s = (src == `SRC_OWN) ? frise_w[c] :
        (src == `SRC_PAIR) ? frise_w[c ^ 1] : 1'b0;
      assign fall_s = (src == `SRC_OWN) ? ffall_w[c] :
        (src == `SRC_PAIR) ? ffall_w[c ^ 1] : 1'b0;
      assign edge_s = en & ((pol & npol) ? (rise_s | fall_s) :
        (pol ? fall_s : rise_s));

      // event prescaler: 1, 2, 4 or 8 edges per capture
      assign plim = (ediv == 2'b00) ? 3'd0 : (ediv == 2'b01) ? 3'd1 :
        (ediv == 2'b10) ? 3'd3 : 3'd7;
      assign cap_evt = edge_s & (pcnt_q == plim);
      assign cap = cap_evt | swe[c];

      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          pcnt_q <= 3'd0;
        end else if (!en || !in_mode || cap_evt) begin
          pcnt_q <= 3'd0;
        end else if (edge_s) begin
          pcnt_q <= pcnt_q + 1'b1;
        end
      end

      always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          ccv_q <= {CNT_W{1'b0}};
          capf_q <= 1'b0;
          ovcf_q <= 1'b0;
          dma_q <= 1'b0;
        end else begin
          if (in_mode && cap) begin
            ccv_q <= cnt_q;
          end else if (!in_mode && wr_ccv[c]) begin
            ccv_q <= pwdata_i[CNT_W-1:0];
          end
          // set wins over a simultaneous clear
          capf_q <= (capf_q & ~(wr_stat & pwdata_i[`STAT_CAPF + c])) |
            cap;
          ovcf_q <= (ovcf_q & ~(wr_stat & pwdata_i[`STAT_OVCF + c])) |
            (cap & capf_q);
          dma_q <= cap & cde_q[c];
        end
      end

      assign capf_w[c] = capf_q;
      assign ovcf_w[c] = ovcf_q;
      assign dma_w[c] = dma_q;
      assign ccv_w[CNT_W*c +: CNT_W] = ccv_q;
    end
  endgenerate

  // read mux, sampled in the setup cycle so data is ready at access
  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr_i)
      `OFS_CTRL: begin
        rd_mux[4:0] = ctrl_q;
        rd_mux[`CTRL_DIR] = dir_q;
      end
      `OFS_STAT: begin
        rd_mux[`STAT_UPF] = upf_q;
        rd_mux[`STAT_CAPF +: NCH] = capf_w;
        rd_mux[`STAT_OVCF +: NCH] = ovcf_w;
      end
      `OFS_EVT: rd_mux = 32'h0000_0000;
      `OFS_IEN: begin
        rd_mux[`IEN_UIE] = uie_q;
        rd_mux[`IEN_CIE +: NCH] = cie_q;
        rd_mux[`IEN_CDE +: NCH] = cde_q;
      end
      `OFS_CHMODE: rd_mux = chmode_q;
      `OFS_CHEN: rd_mux[15:0] = chen_q;
      `OFS_CNT: rd_mux[CNT_W-1:0] = cnt_q;
      `OFS_PSC: rd_mux[PSC_W-1:0] = psc_buf_q;
      `OFS_ARR: rd_mux[CNT_W-1:0] = arr_buf_q;
      `OFS_REP: rd_mux[REP_W-1:0] = rep_buf_q;
      `OFS_CCV0: rd_mux[CNT_W-1:0] = ccv_w[0 +: CNT_W];
      `OFS_CCV1: rd_mux[CNT_W-1:0] = ccv_w[CNT_W +: CNT_W];
      `OFS_CCV2: rd_mux[CNT_W-1:0] = ccv_w[2*CNT_W +: CNT_W];
      `OFS_CCV3: rd_mux[CNT_W-1:0] = ccv_w[3*CNT_W +: CNT_W];
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      irq_o <= 1'b0;
      dma_req_o <= {NCH{1'b0}};
    end else begin
      pready_o <= 1'b1;
      if (setup) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
        pslverr_o <= ~rd_hit;
      end
      irq_o <= |(capf_w & cie_q) | (upf_q & uie_q);
      dma_req_o <= dma_w;
    end
  end

endmodule

// ### verif/timer_ccc_properties.sv
// Purpose: port-level properties of the centre counter and capture timer
// Assumes: interrupt and dma enables only change through apb writes
// Notes: enable bits are shadowed from apb write traffic
`include "timer_ccc_defines.vh"
module timer_ccc_properties #(
  parameter NCH = 4
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire [NCH-1:0] chan_pin_i,
  input wire irq_o,
  input wire [NCH-1:0] dma_req_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  reg [12:0] ien_q;
  wire wr_acc = psel_i & penable_i & pwrite_i & pready_o;
  wire swe0 = wr_acc && paddr_i == `OFS_EVT && pwdata_i[1];
  always @(posedge clk_sys_i) begin
    if (!rst_n_i)
      ien_q <= 13'h0000;
    else if (wr_acc && paddr_i == `OFS_IEN)
      ien_q <= pwdata_i[12:0];
  end
  property p_dma_gate;
    (dma_req_o & ~ien_q[12:9]) == 0;
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("dma without enable");
  property p_dma_pulse;
    (dma_req_o & $past(dma_req_o)) == 0;
  endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("dma not a pulse");
  property p_sw_dma;
    swe0 && ien_q[9] |-> ##[1:4] dma_req_o[0];
  endproperty
  a_sw_dma: assert property (p_sw_dma) else $error("no dma on sw event");
  property p_sw_irq;
    swe0 && ien_q[1] |-> ##[1:4] irq_o;
  endproperty
  a_sw_irq: assert property (p_sw_irq) else $error("no irq on sw event");
  property p_irq_gate;
    irq_o |-> ien_q[4:0] != 0 || $past(ien_q[4:0]) != 0;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
  property p_ready;
    $past(rst_n_i) |-> pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_slverr;
    psel_i && !penable_i && paddr_i > `OFS_CCV3 |=> pslverr_o;
  endproperty
  a_slverr: assert property (p_slverr) else $error("no slverr");
  property p_evt_read;
    psel_i && !penable_i && !pwrite_i && paddr_i == `OFS_EVT |=> !prdata_o;
  endproperty
  a_evt_read: assert property (p_evt_read) else $error("event reads nonzero");
endmodule
bind timer_center_count_capture timer_ccc_properties #(.NCH(NCH)) u_chk (
  .clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .chan_pin_i, .irq_o, .dma_req_o);

// ### verif/pin_model.sv
// Purpose: drives the four channel pins as an outside signal source
// Assumes: levels are commanded by the bench
// Notes: one cycle of lag stands in for board delay
module pin_model (
  input wire clk_i,
  input wire [3:0] lvl_i,
  output reg [3:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_o = 4'h0;
  always @(posedge clk_i) begin
    pin_o <= lvl_i;
  end
endmodule

// ### verif/testbench.sv
// Purpose: self-checking bench for the centre counter and capture timer
// Assumes: zero-wait apb slave, filter 0, one edge per capture, except channel 2 in t_filt
// Notes: prescale 29 keeps each count long enough to be seen by polling
`include "timer_ccc_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk_sys_i = 0;
  reg rst_n_i = 0;
  reg psel = 0;
  reg pen = 0;
  reg pwr = 0;
  reg [7:0] pa = 8'h00;
  reg [31:0] pwd = 32'h0000_0000;
  reg [3:0] lvl = 4'h0;
  reg [31:0] rd;
  reg rerr;
  reg [15:0] mx;
  reg dn;
  wire [3:0] pins;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire irq;
  wire [3:0] dma;
  integer err_count = 0;
  integer checked = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  pin_model i_pin_model (.clk_i(clk_sys_i), .lvl_i(lvl), .pin_o(pins));
  timer_center_count_capture i_timer_center_count_capture (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .chan_pin_i(pins), .irq_o(irq), .dma_req_o(dma));
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_sys_i);
    pen <= 1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  task chk(input [31:0] s, input [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  // polls count and direction back to back, quicker than one count lasts
  task meas(input integer n);
    integer i;
    mx = 0;
    dn = 0;
    for (i = 0; i < n; i++) begin
      apb(0, `OFS_CNT, 0);
      if (rd[15:0] > mx) mx = rd[15:0];
      apb(0, `OFS_CTRL, 0);
      if (rd[`CTRL_DIR]) dn = 1;
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task t_reset;
    apb(0, `OFS_ARR, 0);
    chk(rd, 32'h0000_FFFF);
    apb(0, `OFS_CTRL, 0);
    chk(rd, 32'h0000_0000);
    apb(1, 8'h40, 32'h0000_0001);
    chk(rerr, 1);
    apb(0, `OFS_EVT, 0);
    chk(rd, 32'h0000_0000);
    $display("done t_reset");
  endtask
  task t_centre;
    apb(1, `OFS_PSC, 32'h0000_001D);
    apb(1, `OFS_ARR, 32'h0000_0004);
    apb(1, `OFS_EVT, 32'h0000_0001);
    apb(0, `OFS_CNT, 0);
    chk(rd, 32'h0000_0000);
    apb(1, `OFS_STAT, 32'h0000_0001);
    apb(1, `OFS_CTRL, 32'h0000_0001);
    meas(50);
    chk(mx, 16'h0004);
    chk(dn, 1);
    apb(0, `OFS_STAT, 0);
    chk(rd[0], 1);
    $display("done t_centre");
  endtask
  task t_block;
    apb(1, `OFS_CTRL, 32'h0000_0007);
    apb(1, `OFS_STAT, 32'h0000_0001);
    apb(1, `OFS_ARR, 32'h0000_0006);
    meas(50);
    chk(mx, 16'h0004);
    apb(0, `OFS_STAT, 0);
    chk(rd[0], 0);
    apb(1, `OFS_CTRL, 32'h0000_0005);
    meas(70);
    meas(70);
    chk(mx, 16'h0006);
    $display("done t_block");
  endtask
  task t_swe;
    apb(1, `OFS_IEN, 32'h0000_0202);
    apb(1, `OFS_CHMODE, 32'h0000_0001);
    apb(1, `OFS_EVT, 32'h0000_0002);
    apb(0, `OFS_STAT, 0);
    chk(rd[1], 1);
    chk(irq, 1);
    apb(1, `OFS_EVT, 32'h0000_0002);
    apb(0, `OFS_STAT, 0);
    chk(rd[9], 1);
    apb(1, `OFS_STAT, 32'h0000_0202);
    repeat (3) @(posedge clk_sys_i);
    chk(irq, 0);
    $display("done t_swe");
  endtask
  task t_pin;
    apb(1, `OFS_CHMODE, 32'h0000_0201);
    apb(1, `OFS_CHEN, 32'h0000_0031);
    apb(1, `OFS_STAT, 32'hFFFF_FFFF);
    lvl <= 4'h1;
    repeat (10) @(posedge clk_sys_i);
    apb(0, `OFS_STAT, 0);
    chk(rd[2:1], 2'b01);
    lvl <= 4'h0;
    repeat (10) @(posedge clk_sys_i);
    apb(0, `OFS_STAT, 0);
    chk(rd[2:1], 2'b11);
    apb(1, `OFS_CCV0, 32'h0000_1234);
    apb(0, `OFS_CCV0, 0);
    chk(rd[15:0] == 16'h1234, 0);
    apb(1, `OFS_CTRL, 32'h0000_0015);
    apb(1, `OFS_STAT, 32'hFFFF_FFFF);
    lvl <= 4'h2;
    repeat (10) @(posedge clk_sys_i);
    apb(0, `OFS_STAT, 0);
    chk(rd[1], 1);
    apb(1, `OFS_CTRL, 32'h0000_000D);
    apb(1, `OFS_CNT, 32'h0000_0003);
    lvl <= 4'h3;
    repeat (8) @(posedge clk_sys_i);
    apb(0, `OFS_CNT, 0);
    chk(rd, 32'h0000_0000);
    $display("done t_pin");
  endtask
  // channel 2: filter 3, both edges, two edges per capture
  task t_filt;
    apb(1, `OFS_CHMODE, 32'h0035_0201);
    apb(1, `OFS_CHEN, 32'h0000_0731);
    apb(1, `OFS_STAT, 32'hFFFF_FFFF);
    lvl <= 4'h7;
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    lvl <= 4'h3;
    repeat (10) @(posedge clk_sys_i);
    lvl <= 4'h7;
    repeat (12) @(posedge clk_sys_i);
    apb(0, `OFS_STAT, 0);
    chk(rd[3], 0);
    lvl <= 4'h3;
    repeat (12) @(posedge clk_sys_i);
    apb(0, `OFS_STAT, 0);
    chk(rd[3], 1);
    $display("done t_filt");
  endtask
  // the whole sequence needs under 4000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1;
    t_reset;
    t_centre;
    t_block;
    t_swe;
    t_pin;
    t_filt;
    finish_test;
  end
endmodule
